// File: common/pbs_pkg.sv
// constants, types and states shared by the power-on boot sequencer
package pbs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ          = 20_000_000;  // system clock rate
  localparam longint HOLD_TIME_MS    = 100;         // least power-up hold
  // least time, rounded up to whole cycles
  localparam int     HOLD_CYCLES     = int'((HOLD_TIME_MS * CLK_HZ + 999) / 1000);
  localparam int     INSTR_INIT_CYC  = 16;          // init pulse for reset instruction

  // ----------------------------------------------------------------
  // vector rom and address map (word addresses)
  // ----------------------------------------------------------------
  localparam int          STRAP_W        = 3;           // high rom address inputs
  localparam int          LOW_ADDR_W     = 2;           // low rom address inputs
  localparam int          ROM_ADDR_W     = STRAP_W + LOW_ADDR_W;
  localparam int          DATA_W         = 16;          // rom and bus word
  localparam logic [2:0]  VECTOR_READS   = 3'h4;        // reads before latch sets
  localparam logic [15:0] JUMP_TABLE_BASE = 16'h0400;   // jump table in program memory
  localparam logic [15:0] TIMER_BASE     = 16'hff00;    // timer reload words
  localparam int          TIMER_CH       = 3;           // timer channels
  localparam int          RTC_CH         = 2;           // real-time clock channel

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_HOLD  = 2'b00,   // halt and init both asserted
    PH_INIT  = 2'b01,   // init only, reset instruction
    PH_RUN   = 2'b10    // normal running
  } pbs_phase_t;

  // processor side bus request, same clock
  typedef struct packed {
    logic        rd;     // one-cycle read strobe
    logic        wr;     // one-cycle write strobe
    logic [15:0] addr;   // word address
    logic [15:0] wdata;  // write data
  } pbs_cpu_req_t;

  // vector rom word for an address: pointer into the jump table
  function automatic logic [15:0] vectorWord(input logic [ROM_ADDR_W-1:0] idx);
    return JUMP_TABLE_BASE + {9'h000, idx, 2'h0};
  endfunction

endpackage

// File: hw/pbs_power_on_boot_sequencer.sv
// power-up halt/init sequencing, boot vector rom and programmable timer
`timescale 1ns/1ps
module pbs_power_on_boot_sequencer #(
  parameter int HOLD_CYCLES = pbs_pkg::HOLD_CYCLES  // power-up hold length
) (
  // clock and power-on reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // reset sources
  input  wire logic                   resetDetect,      // pin, asynchronous
  input  wire logic                   resetInstr,       // processor, same clock
  // straps
  input  wire logic [2:0]             boot_select_straps,  // pins
  // processor bus
  input  wire pbs_pkg::pbs_cpu_req_t  cpuReq,
  output logic                        cpuReadValid,     // read answer pulse
  output logic [15:0]                 cpuReadData,      // vector rom word
  // backplane control
  output logic                        bus_halt_n,       // to processor
  output logic                        bus_init_n,       // to processor
  output logic                        cardInitN,        // to interface cards
  output logic                        vectorRomEnN,     // latch output
  output logic                        ramZeroBlockN,    // low blocks location zero
  // timer outputs
  output logic [1:0]                  baudClk,          // serial adapter bit clocks
  output logic                        rtcInterrupt      // periodic pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pbs_pkg::pbs_phase_t phase;      // sequencing phase
    logic [31:0]         count;      // phase timer
    logic                rdSync1;    // reset detect, first stage
    logic                rdSync2;    // reset detect, second stage
    logic [2:0]          stSync1;    // straps, first stage
    logic [2:0]          stSync2;    // straps, second stage
    logic [2:0]          straps;     // straps caught during hold
    logic                latchQ;     // vector latch, low enables rom
    logic [2:0]          reads;      // vector reads since hold
    logic                rdValid;    // read answer
    logic [15:0]         rdData;     // read word
    logic                haltN;      // halt line
    logic                initN;      // init line
  } pbs_seq_state_t;

  pbs_seq_state_t s_q;  // registered state
  pbs_seq_state_t s_d;  // next state

  logic [pbs_pkg::TIMER_CH-1:0] tmrLoad;   // per-channel reload write
  logic [pbs_pkg::TIMER_CH-1:0] tmrWave;   // channel square waves
  logic [pbs_pkg::TIMER_CH-1:0] tmrTick;   // channel period pulses
  logic                         vecHit;    // read falls in vector area
  logic [pbs_pkg::ROM_ADDR_W-1:0] romIdx;  // rom address

  // rom address: straps high, processor address low
  assign romIdx = {s_q.straps, cpuReq.addr[1:0]};
  // vector area is the first four words of memory
  assign vecHit = (cpuReq.addr[15:2] == 14'h0000);

  // ----------------------------------------------------------------
  // sequencing and vector rom
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.rdValid = 1'b0;
    // synchronisers: first stage read only by the second
    s_d.rdSync1 = resetDetect;
    s_d.rdSync2 = s_q.rdSync1;
    s_d.stSync1 = boot_select_straps;
    s_d.stSync2 = s_q.stSync1;

    unique case (s_q.phase)
      pbs_pkg::PH_HOLD: begin
        // halt and init together for the full hold time
        s_d.haltN  = 1'b0;
        s_d.initN  = 1'b0;
        s_d.latchQ = 1'b0;
        s_d.reads  = 3'h0;
        s_d.straps = s_q.stSync2;
        if (s_q.count >= 32'(HOLD_CYCLES - 1)) begin
          s_d.phase = pbs_pkg::PH_RUN;
          s_d.count = 32'h0;
          s_d.haltN = 1'b1;
          s_d.initN = 1'b1;
        end else begin
          s_d.count = s_q.count + 32'h1;
        end
      end
      pbs_pkg::PH_INIT: begin
        // reset instruction: init only, processor keeps running
        s_d.initN = 1'b0;
        if (s_q.count >= 32'(pbs_pkg::INSTR_INIT_CYC - 1)) begin
          s_d.phase = pbs_pkg::PH_RUN;
          s_d.count = 32'h0;
          s_d.initN = 1'b1;
        end else begin
          s_d.count = s_q.count + 32'h1;
        end
      end
      pbs_pkg::PH_RUN: begin
        s_d.count = 32'h0;
        if (resetInstr) begin
          s_d.phase = pbs_pkg::PH_INIT;
          s_d.initN = 1'b0;
        end
      end
      default: begin
        // illegal code: restart the full sequence
        s_d.phase = pbs_pkg::PH_HOLD;
        s_d.count = 32'h0;
      end
    endcase

    // reset condition detected: full halt and init sequence again
    if (s_q.rdSync2) begin
      s_d.phase = pbs_pkg::PH_HOLD;
      s_d.count = 32'h0;
      s_d.haltN = 1'b0;
      s_d.initN = 1'b0;
      s_d.latchQ = 1'b0;
    end

    // vector rom answers reads outside the hold phase while the latch output is low
    if (cpuReq.rd && vecHit && !s_q.latchQ && s_q.phase != pbs_pkg::PH_HOLD) begin
      s_d.rdValid = 1'b1;
      s_d.rdData  = pbs_pkg::vectorWord(romIdx);
      if (s_q.reads == pbs_pkg::VECTOR_READS - 3'h1) begin
        s_d.latchQ = 1'b1;
      end else begin
        s_d.reads = s_q.reads + 3'h1;
      end
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q        <= '0;
      s_q.phase  <= pbs_pkg::PH_HOLD;   // power-up starts the hold
      s_q.haltN  <= 1'b0;
      s_q.initN  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // programmable timer: three channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < pbs_pkg::TIMER_CH; ch++) begin : g_tmr
      // reload words sit at consecutive addresses from the base
      assign tmrLoad[ch] = cpuReq.wr
        && (cpuReq.addr == pbs_pkg::TIMER_BASE + 16'(ch));
      pbs_timer_channel u_ch (
        .clk       (clk),
        .reset     (reset),
        .clear     (!s_q.initN),        // cleared with the cards
        .load      (tmrLoad[ch]),
        .loadValue (cpuReq.wdata),
        .clkOut    (tmrWave[ch]),
        .tick      (tmrTick[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign bus_halt_n    = s_q.haltN;
  assign bus_init_n    = s_q.initN;
  assign cardInitN     = s_q.initN;              // program memory not wired
  assign vectorRomEnN  = s_q.latchQ;
  assign ramZeroBlockN = s_q.latchQ;
  assign cpuReadValid  = s_q.rdValid;
  assign cpuReadData   = s_q.rdData;
  assign baudClk       = tmrWave[1:0];
  assign rtcInterrupt  = tmrTick[pbs_pkg::RTC_CH];

endmodule // pbs_power_on_boot_sequencer

// File: hw/pbs_timer_channel.sv
// one clock generator channel of the programmable timer
`timescale 1ns/1ps
module pbs_timer_channel (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // programming
  input  wire logic        clear,      // bus init clears the channel
  input  wire logic        load,       // one-cycle reload write
  input  wire logic [15:0] loadValue,  // period in clocks, zero stops
  // outputs
  output logic             clkOut,     // square wave
  output logic             tick        // one-cycle pulse per period
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] reload;  // programmed period
    logic [15:0] count;   // down counter
    logic        wave;    // output level
    logic        tick;    // period pulse
  } pbs_tmr_state_t;

  pbs_tmr_state_t s_q;  // registered state
  pbs_tmr_state_t s_d;  // next state

  // next state: count down, reload and toggle when the count reaches one
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (clear) begin                  // held clear while init asserted
      s_d = '0;
    end else if (load) begin          // new period restarts the count
      s_d.reload = loadValue;
      s_d.count  = loadValue;
    end else if (s_q.reload != 16'h0000) begin
      if (s_q.count <= 16'h0001) begin
        s_d.count = s_q.reload;
        s_d.wave  = ~s_q.wave;
        s_d.tick  = 1'b1;
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clkOut = s_q.wave;
  assign tick   = s_q.tick;

endmodule // pbs_timer_channel

// File: test/pbs_boot_sva.sv
// port checker for the power-on boot sequencer, with its bind
`timescale 1ns/1ps
module pbs_boot_checker #(
  parameter int HOLD_CYCLES = pbs_pkg::HOLD_CYCLES  // hold length
) (
  // clock and reset sources
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  resetDetect,
  input wire logic                  resetInstr,
  // straps and processor bus
  input wire logic [2:0]            boot_select_straps,
  input wire pbs_pkg::pbs_cpu_req_t cpuReq,
  input wire logic                  cpuReadValid,
  input wire logic [15:0]           cpuReadData,
  // backplane and timer
  input wire logic                  bus_halt_n,
  input wire logic                  bus_init_n,
  input wire logic                  cardInitN,
  input wire logic                  vectorRomEnN,
  input wire logic                  ramZeroBlockN,
  input wire logic [1:0]            baudClk,
  input wire logic                  rtcInterrupt
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  int holdCnt;  // cycles with halt low
  int ansCnt;   // answers since last hold
  // counts restart on reset; answers only count once halt is lifted
  always_ff @(posedge clk) begin
    holdCnt <= (reset || bus_halt_n) ? 0 : holdCnt + 1;
    ansCnt  <= (reset || !bus_halt_n) ? 0 : ansCnt + int'(cpuReadValid);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence vecRead;
    cpuReq.rd && cpuReq.addr[15:2] == 14'h0 && !vectorRomEnN && bus_halt_n;
  endsequence
  sequence initLow8;
    (!bus_init_n && bus_halt_n) [*8];
  endsequence
  AST_HALT_HOLD: assert property ($rose(bus_halt_n) |-> holdCnt >= HOLD_CYCLES)
    else $error("halt lifted before the hold ran out");
  AST_HALT_WITH_INIT: assert property (!bus_halt_n |-> !bus_init_n)
    else $error("halt low without init");
  AST_CARD_INIT: assert property (cardInitN == bus_init_n)
    else $error("card init differs from processor init");
  AST_LATCH_CLEAR: assert property (!bus_halt_n ##1 !bus_halt_n |-> !vectorRomEnN)
    else $error("halt did not clear the latch");
  AST_ZERO_BLOCK: assert property (ramZeroBlockN == vectorRomEnN)
    else $error("location zero block out of step with rom enable");
  AST_VEC_WORD: assert property (vecRead |=> cpuReadValid && cpuReadData == pbs_pkg::JUMP_TABLE_BASE
      + {9'h0, $past(boot_select_straps), $past(cpuReq.addr[1:0]), 2'h0})
    else $error("vector word wrong or missing");
  AST_NO_STRAY: assert property (cpuReadValid |-> $past(cpuReq.rd)
      && $past(cpuReq.addr[15:2]) == 14'h0 && $past(vectorRomEnN) == 1'b0)
    else $error("answer without an accepted vector read");
  AST_LATCH_SET: assert property ($rose(vectorRomEnN) |-> cpuReadValid && ansCnt == 3)
    else $error("latch set at the wrong answer");
  AST_INSTR_INIT: assert property (resetInstr && bus_halt_n && bus_init_n
      |=> initLow8 ##1 initLow8 ##1 bus_init_n)
    else $error("reset instruction init pulse wrong");
  AST_TIMER_CLEAR: assert property (!bus_init_n ##1 !bus_init_n
      |-> baudClk == 2'h0 && !rtcInterrupt)
    else $error("timer running during init");
endmodule // pbs_boot_checker

bind pbs_power_on_boot_sequencer pbs_boot_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

// File: test/pbs_cpu_model.sv
// behavioural processor on the backplane bus facing the sequencer
`timescale 1ns/1ps
module pbs_cpu_model (
  // clock and halt
  input  wire logic       clk,
  input  wire logic       bus_halt_n,
  // bus request
  output pbs_pkg::pbs_cpu_req_t cpuReq
);
  initial cpuReq = '0;
  // one request per call just after the edge, so calls run back to back
  task automatic req(input logic r, w, input logic [15:0] a, d);
    @(posedge clk);
    #1 cpuReq = '{r, w, a, d};
  endtask
  // single read, then bus released showing inverted values
  task automatic rd1(input logic [15:0] a);
    req(1'b1, 1'b0, a, 16'h0);
    req(1'b0, 1'b0, ~a, 16'hffff);
  endtask
  // boot fetch: two long words, stack pointer then pc, never while halted
  task automatic boot;
    while (bus_halt_n !== 1'b1) @(posedge clk);
    for (int i = 0; i < 4; i++) req(1'b1, 1'b0, 16'(i), 16'h0);
    req(1'b0, 1'b0, 16'hfffc, 16'hffff);
  endtask
  // timer reload write, one word per channel
  task automatic prog(input int ch, input logic [15:0] v);
    req(1'b0, 1'b1, pbs_pkg::TIMER_BASE + 16'(ch), v);
    req(1'b0, 1'b0, ~pbs_pkg::TIMER_BASE, ~v);
  endtask
endmodule // pbs_cpu_model

// File: test/tb_top.sv
// self-checking bench for the power-on boot sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = 20;  // shortened hold
  logic clk, reset, resetDetect, resetInstr, cpuReadValid, rtcInterrupt;
  logic bus_halt_n, bus_init_n, cardInitN, vectorRomEnN, ramZeroBlockN;
  logic [2:0]  boot_select_straps;
  logic [15:0] cpuReadData, w;
  logic [1:0]  baudClk;
  pbs_pkg::pbs_cpu_req_t cpuReq;
  logic [15:0] expQ[$];  // expected read words, oldest first
  int n_errors, cmp_count, n;
  wire [2:0] tmr = {rtcInterrupt, baudClk};  // timer outputs by channel
  pbs_power_on_boot_sequencer #(.HOLD_CYCLES(HOLD)) DUT (.*);
  pbs_cpu_model cpu (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // edges until halt goes high, bounded
  task automatic waitHalt(output int c);
    c = 0;
    while (bus_halt_n !== 1'b1 && c < 99) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  // cycles between two rises of one timer output; 200 means none
  task automatic period(input int s, output int n);
    int r = 0;
    int g = 0;  // edges watched, bounds a stopped output
    logic p = 1'b1;
    n = 0;
    while (r < 2 && g < 200) begin
      p = tmr[s];
      @(negedge clk);
      g++;
      if (r > 0) n++;
      if (tmr[s] === 1'b1 && p === 1'b0) r++;
    end
    if (r < 2) n = 200;
  endtask
  // monitor: every answer takes the oldest note; a stray one mismatches
  always @(negedge clk) begin
    if (cpuReadValid === 1'b1) check(cpuReadData, (expQ.size() > 0) ? expQ.pop_front() : ~cpuReadData);
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {reset, resetDetect, resetInstr, n_errors, cmp_count} = '0;
    reset = 1'b1;
    n = $urandom(63382);
    boot_select_straps = 3'($urandom);
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    check({bus_halt_n, bus_init_n, cardInitN, vectorRomEnN, ramZeroBlockN}, 5'h0);
    waitHalt(n);
    check(16'(n), 16'(HOLD));
    $display("test power-up hold done");
    // refused reads, then the four boot words back to back
    cpu.rd1(16'h0004);
    cpu.rd1(16'h8001);
    for (int i = 0; i < 4; i++) expQ.push_back(pbs_pkg::JUMP_TABLE_BASE + {9'h0, boot_select_straps, 2'(i), 2'h0});
    cpu.boot();
    repeat (2) @(posedge clk);
    check({vectorRomEnN, ramZeroBlockN}, 2'h3);
    cpu.rd1(16'h0000);
    repeat (3) @(posedge clk);
    check(16'(expQ.size()), 16'h0);
    $display("test vector boot done");
    // every timer channel with a random reload
    for (int ch = 0; ch < 3; ch++) begin
      w = 16'(3 + $urandom % 10);
      cpu.prog(ch, w);
      period(ch, n);
      check(16'(n), (ch == 2) ? w : w << 1);
    end
    $display("test timer done");
    // reset instruction: init alone for a fixed pulse, timer stopped
    @(posedge clk);
    #1 resetInstr = 1'b1;
    @(posedge clk);
    #1 resetInstr = 1'b0;
    n = 0;
    while (bus_init_n === 1'b0 && n < 99) begin
      @(posedge clk);
      #1 n++;
    end
    check(16'(n), 16'd16);
    check(bus_halt_n, 1'b1);
    period(2, n);
    check(16'(n), 16'd200);
    $display("test reset instruction done");
    // reset detect: full hold again, latch cleared, reads refused then served
    @(posedge clk);
    #1 resetDetect = 1'b1;
    repeat (4) @(posedge clk);
    #1 resetDetect = 1'b0;
    cpu.rd1(16'h0000);
    check({bus_halt_n, bus_init_n, cardInitN, vectorRomEnN}, 4'h0);
    waitHalt(n);
    expQ.push_back(pbs_pkg::JUMP_TABLE_BASE + {9'h0, boot_select_straps, 2'h2, 2'h0});
    cpu.rd1(16'h0002);
    repeat (3) @(posedge clk);
    check(16'(expQ.size()), 16'h0);
    $display("test reset detect done");
    tally_and_finish();
  end
endmodule // tb_top
